// ---- pkg/asc_params.svh ----
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH
// register indices; the bus byte address is four times the index
`define ASC_IDX_CFG0      16'hdf40
`define ASC_IDX_DATL      16'hdf42
`define ASC_IDX_DATH      16'hdf43
`define ASC_IDX_STAT      16'hdf45
`define ASC_IDX_IRQ_MASK  16'hdf48
`define ASC_ADDR_W        18
// configuration bit positions
`define ASC_BIT_ENAB      0
`define ASC_BIT_MASTER    1
`define ASC_BIT_RX_SINGLE_CHANNEL    2
`define ASC_BIT_TX_SINGLE_CHANNEL    3
`define ASC_BIT_COMP      4
`define ASC_BIT_EXP       5
`define ASC_BIT_RXIE      6
`define ASC_BIT_TXIE      7
// status bit positions
`define ASC_ST_RX         0
`define ASC_ST_TX         1
`define ASC_CFG0_RESET    8'h00
`define ASC_STAT_RESET    8'h00
`define ASC_MASK_RESET    8'h03
// master serial clock half period in system clocks
`define ASC_SCK_HALF      16'd32
`define ASC_WORD_BITS     16
`endif

// ---- pkg/asc_pkg.sv ----
package asc_pkg;
  typedef struct packed {
    logic tx_irq_enable;
    logic rx_irq_enable;
    logic mulaw_expand_enable;
    logic mulaw_compress_enable;
    logic tx_single_channel;
    logic rx_single_channel;
    logic master;
    logic enable;
  } asc_cfg_t;

  typedef struct packed {
    logic sck;
    logic ws;
    logic sd;
  } asc_serial_t;
endpackage : asc_pkg

// ---- verilog/asc_audio_link.sv ----
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`include "asc_params.svh"
module asc_audio_link (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic [`ASC_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  output logic                        irq,
  input  wire logic                   sck_in,
  input  wire logic                   ws_in,
  input  wire logic                   sd_in,
  output logic                        sck_out,
  output logic                        sck_oe,
  output logic                        ws_out,
  output logic                        ws_oe,
  output logic                        sd_out
);

  // mu-law expansion of one byte to 16-bit linear
  function automatic logic [15:0] asc_expand(input logic [7:0] c);
    logic [7:0]  u;
    logic [14:0] mag;
    u   = ~c;
    mag = 15'(((({11'h0, u[3:0]} << 3) + 15'h84) << u[6:4]) - 15'h84);
    return u[7] ? 16'(-$signed({1'b0, mag})) : {1'b0, mag};
  endfunction : asc_expand

  // 16-bit linear to mu-law byte
  function automatic logic [7:0] asc_compress(input logic [15:0] s);
    logic        sgn;
    logic [15:0] mag;
    logic [2:0]  ex;
    logic [3:0]  man;
    sgn = s[15];
    mag = sgn ? 16'(-$signed(s)) : s;
    if (mag > 16'h7f7b) begin
      mag = 16'h7f7b;
    end
    mag = 16'(mag + 16'h84);
    ex  = 3'h7;
    for (int i = 14; i >= 7; i--) begin
      if (mag[i] == 1'b0 && ex == 3'(i - 7)) begin
        ex = 3'(i - 8);
      end
    end
    man = 4'(mag >> ({1'b0, ex} + 4'h3)); // exponent plus three needs four bits
    return ~{sgn, ex, man};
  endfunction : asc_compress

  asc_pkg::asc_cfg_t cfg_ff;
  logic [7:0]  dat_low_ff;
  logic [7:0]  dat_high_ff;
  logic [1:0]  stat_ff;
  logic [1:0]  mask_ff;
  logic        low_written_ff;
  logic [15:0] tx_buf_ff;
  logic        tx_full_ff;
  logic        rx_full_ff;
  logic        ack_ff;
  logic [`ASC_ADDR_W-1:0] idx;
  logic        wr_go;
  logic        rd_go;
  logic        tx_fetch;
  logic        rx_load;
  logic [15:0] rx_word;

  assign idx   = avs_address >> 2;
  assign wr_go = avs_write & ack_ff; // write lands on the edge that sees waitrequest low
  assign rd_go = avs_read & ~ack_ff;

  // one-wait-state handshake: waitrequest low in the cycle after request
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff          <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_ff          <= (avs_read | avs_write) & ~ack_ff;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_ff);
    end
  end

  // configuration and mask registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff  <= `ASC_CFG0_RESET;
      mask_ff <= 2'(`ASC_MASK_RESET);
    end else if (wr_go && avs_byteenable[0]) begin
      if (idx == `ASC_IDX_CFG0) begin
        cfg_ff <= avs_writedata[7:0];
      end
      if (idx == `ASC_IDX_IRQ_MASK) begin
        mask_ff <= avs_writedata[1:0];
      end
    end
  end

  // data registers and conversion
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dat_low_ff     <= 8'h00;
      dat_high_ff    <= 8'h00;
      low_written_ff <= 1'b0;
      tx_buf_ff      <= 16'h0000;
      tx_full_ff     <= 1'b0;
    end else begin
      if (tx_fetch) begin
        tx_full_ff <= 1'b0;
      end
      if (rx_load) begin
        if (cfg_ff.mulaw_compress_enable) begin
          dat_high_ff <= asc_compress(rx_word);
        end else begin
          {dat_high_ff, dat_low_ff} <= rx_word;
        end
      end
      if (wr_go && avs_byteenable[0] && idx == `ASC_IDX_DATL) begin
        dat_low_ff     <= avs_writedata[7:0];
        low_written_ff <= 1'b1;
      end
      if (wr_go && avs_byteenable[0] && idx == `ASC_IDX_DATH) begin
        low_written_ff <= 1'b0;
        if (!cfg_ff.enable) begin
          // standalone unit, result ready next cycle
          if (cfg_ff.mulaw_expand_enable) begin
            {dat_high_ff, dat_low_ff} <= asc_expand(avs_writedata[7:0]);
          end else if (cfg_ff.mulaw_compress_enable) begin
            dat_high_ff <= asc_compress({avs_writedata[7:0], dat_low_ff});
          end else begin
            dat_high_ff <= avs_writedata[7:0];
          end
        end else begin
          tx_full_ff <= 1'b1;
          if (cfg_ff.mulaw_expand_enable) begin
            tx_buf_ff <= asc_expand(avs_writedata[7:0]);
          end else begin
            tx_buf_ff <= {avs_writedata[7:0], low_written_ff ? dat_low_ff : 8'h00};
          end
        end
      end
    end
  end

  // pin synchronisers
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic       sck_prev_ff;
  logic       ws_prev_ff;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {sck_in, ws_in, sd_in};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // master clock divider
  logic [15:0] div_ff;
  logic        int_sck_ff;
  logic [4:0]  bit_ff;
  logic        int_ws_ff;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff     <= 16'h0000;
      int_sck_ff <= 1'b0;
      bit_ff     <= 5'h00;
      int_ws_ff  <= 1'b0;
    end else if (cfg_ff.enable && cfg_ff.master) begin
      if (div_ff == `ASC_SCK_HALF - 16'd1) begin
        div_ff     <= 16'h0000;
        int_sck_ff <= ~int_sck_ff;
        if (int_sck_ff) begin
          // word select changes with the falling edge
          if (bit_ff == 5'(`ASC_WORD_BITS - 1)) begin
            bit_ff    <= 5'h00;
            int_ws_ff <= ~int_ws_ff;
          end else begin
            bit_ff <= bit_ff + 5'h01;
          end
        end
      end else begin
        div_ff <= div_ff + 16'd1;
      end
    end else begin
      div_ff     <= 16'h0000;
      int_sck_ff <= 1'b0;
      bit_ff     <= 5'h00;
      int_ws_ff  <= 1'b0;
    end
  end

  // clock source selection
  logic cur_sck;
  logic cur_ws;
  assign cur_sck = cfg_ff.master ? int_sck_ff : pin_s2_ff[2];
  assign cur_ws  = cfg_ff.master ? int_ws_ff : pin_s2_ff[1];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev_ff <= 1'b0;
      ws_prev_ff  <= 1'b0;
    end else begin
      sck_prev_ff <= cur_sck;
      ws_prev_ff  <= cur_ws;
    end
  end

  logic sck_rise;
  logic sck_fall;
  assign sck_rise = cfg_ff.enable & cur_sck & ~sck_prev_ff;
  assign sck_fall = cfg_ff.enable & ~cur_sck & sck_prev_ff;

  // serial shifter: frame starts one bit after ws change
  logic [15:0] tx_sh_ff;
  logic [15:0] rx_sh_ff;
  logic [4:0]  rx_cnt_ff;
  logic        ws_seen_ff;
  logic        chan_ff;
  logic        repeat_ff;
  logic [15:0] mono_hold_ff;
  logic        ws_edge_pending_ff;
  logic [15:0] rx_bit;
  assign tx_fetch = sck_fall && ws_edge_pending_ff && !(cfg_ff.tx_single_channel && repeat_ff);
  assign rx_load  = sck_rise && ws_edge_pending_ff && rx_cnt_ff != 5'h00 && rx_cnt_ff <= 5'd16
                    && !(cfg_ff.rx_single_channel && chan_ff);
  assign rx_bit   = (pin_s2_ff[0] && rx_cnt_ff < 5'd16) ? (16'h8000 >> rx_cnt_ff) : 16'h0000;
  assign rx_word  = rx_sh_ff | rx_bit; // includes the bit on this rise

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sh_ff           <= 16'h0000;
      rx_sh_ff           <= 16'h0000;
      rx_cnt_ff          <= 5'h1f; // no word framed yet
      ws_seen_ff         <= 1'b0;
      chan_ff            <= 1'b0;
      repeat_ff          <= 1'b0;
      mono_hold_ff       <= 16'h0000;
      ws_edge_pending_ff <= 1'b0;
      sd_out             <= 1'b0;
    end else if (!cfg_ff.enable) begin
      rx_cnt_ff          <= 5'h1f;
      ws_edge_pending_ff <= 1'b0;
      repeat_ff          <= 1'b0;
      sd_out             <= 1'b0;
    end else begin
      if (sck_fall) begin
        if (ws_seen_ff != cur_ws) begin
          ws_seen_ff         <= cur_ws;
          ws_edge_pending_ff <= 1'b1;
          sd_out             <= tx_sh_ff[15];
          tx_sh_ff           <= {tx_sh_ff[14:0], 1'b0}; // zeros after the word
        end else if (ws_edge_pending_ff) begin
          ws_edge_pending_ff <= 1'b0;
          chan_ff            <= ws_seen_ff;
          if (cfg_ff.tx_single_channel && repeat_ff) begin
            tx_sh_ff  <= {mono_hold_ff[14:0], 1'b0};
            sd_out    <= mono_hold_ff[15];
            repeat_ff <= 1'b0;
          end else begin
            mono_hold_ff <= tx_full_ff ? tx_buf_ff : 16'h0000;
            tx_sh_ff     <= {(tx_full_ff ? tx_buf_ff[14:0] : 15'h0), 1'b0};
            sd_out       <= tx_full_ff ? tx_buf_ff[15] : 1'b0;
            repeat_ff    <= cfg_ff.tx_single_channel;
          end
        end else begin
          sd_out   <= tx_sh_ff[15];
          tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
        end
      end
      if (sck_rise) begin
        if (ws_edge_pending_ff) begin
          // old word ends with this bit, next word starts empty
          rx_cnt_ff <= 5'h00;
          rx_sh_ff  <= 16'h0000;
        end else if (rx_cnt_ff < 5'd16) begin
          rx_cnt_ff <= rx_cnt_ff + 5'h01; // low bits past 16 are dropped
          rx_sh_ff  <= rx_word;
        end
      end
    end
  end

  // sticky request flags, set wins over clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_ff    <= 2'(`ASC_STAT_RESET);
      rx_full_ff <= 1'b0;
    end else begin
      if (rd_go && idx == `ASC_IDX_DATH) begin
        stat_ff[`ASC_ST_RX] <= 1'b0;
        rx_full_ff          <= 1'b0;
      end
      if (wr_go && avs_byteenable[0] && idx == `ASC_IDX_DATH) begin
        stat_ff[`ASC_ST_TX] <= 1'b0;
      end
      if (wr_go && avs_byteenable[0] && idx == `ASC_IDX_STAT) begin
        stat_ff <= stat_ff & ~avs_writedata[1:0];
      end
      if (rx_load) begin
        stat_ff[`ASC_ST_RX] <= 1'b1;
        rx_full_ff          <= 1'b1;
      end
      if (tx_fetch) begin
        stat_ff[`ASC_ST_TX] <= 1'b1;
      end
    end
  end

  // interrupt and pin outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq     <= 1'b0;
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
      ws_out  <= 1'b0;
      ws_oe   <= 1'b0;
    end else begin
      irq     <= (stat_ff[`ASC_ST_RX] & mask_ff[`ASC_ST_RX] & cfg_ff.rx_irq_enable)
               | (stat_ff[`ASC_ST_TX] & mask_ff[`ASC_ST_TX] & cfg_ff.tx_irq_enable);
      sck_out <= int_sck_ff;
      ws_out  <= int_ws_ff;
      sck_oe  <= cfg_ff.enable & cfg_ff.master;
      ws_oe   <= cfg_ff.enable & cfg_ff.master;
    end
  end

  // read data mux
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      unique case (idx)
        `ASC_IDX_CFG0:     avs_readdata <= {24'h0, cfg_ff};
        `ASC_IDX_DATL:     avs_readdata <= {24'h0, dat_low_ff};
        `ASC_IDX_DATH:     avs_readdata <= {24'h0, dat_high_ff};
        `ASC_IDX_STAT:     avs_readdata <= {29'h0, rx_full_ff, stat_ff};
        `ASC_IDX_IRQ_MASK: avs_readdata <= {30'h0, mask_ff};
        default:           avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : asc_audio_link

// ---- test/asc_audio_link_props.sv ----
`timescale 1ns/1ps
`include "asc_params.svh"
module asc_audio_link_props (
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  input wire logic [`ASC_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic                   irq,
  input wire logic                   sck_out,
  input wire logic                   sck_oe,
  input wire logic                   ws_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  asc_pkg::asc_cfg_t cfg_ff;
  logic              prev_sck_ff;
  logic              armed_ff;
  logic [7:0]        half_ff;
  logic [15:0]       idx;
  logic              done;
  logic              mapped;
  assign idx    = avs_address[`ASC_ADDR_W-1:2];
  assign done   = !avs_waitrequest;
  assign mapped = idx inside {`ASC_IDX_CFG0, `ASC_IDX_DATL, `ASC_IDX_DATH, `ASC_IDX_STAT, `ASC_IDX_IRQ_MASK};
  // shadow of the config byte as software wrote it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ff <= `ASC_CFG0_RESET;
    end else if (avs_write && done && idx == `ASC_IDX_CFG0 && avs_byteenable[0]) begin
      cfg_ff <= avs_writedata[7:0];
    end
  end
  // cycles since the last serial clock change
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_sck_ff <= 1'b0;
      armed_ff    <= 1'b0;
      half_ff     <= 8'h00;
    end else begin
      prev_sck_ff <= sck_out;
      half_ff     <= (sck_out != prev_sck_ff) ? 8'h00 : half_ff + 8'h01;
      armed_ff    <= sck_oe && (armed_ff || sck_out != prev_sck_ff);
    end
  end
  sequence s_req_waiting;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_one_wait_state: assert property (s_req_waiting |=> s_answer)
    else $error("bus answer not after one wait state");
  a_slave_no_drive: assert property (!(cfg_ff.enable && cfg_ff.master) [*3] |-> !sck_oe && !ws_oe)
    else $error("link clock driven outside master mode");
  a_master_drives: assert property ((cfg_ff.enable && cfg_ff.master) [*3] |-> sck_oe && ws_oe)
    else $error("link clock not driven in master mode");
  a_sck_half_period: assert property (armed_ff && sck_out != prev_sck_ff |-> half_ff == 8'h1f)
    else $error("serial clock half period wrong");
  a_irq_quiet: assert property ((!cfg_ff.tx_irq_enable && !cfg_ff.rx_irq_enable) [*2] |-> !irq)
    else $error("interrupt with both enables clear");
  a_unmapped_zero: assert property (avs_read && done && !mapped |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_readback: assert property (avs_read && done && idx == `ASC_IDX_CFG0 |-> avs_readdata[7:0] == cfg_ff)
    else $error("config readback differs");
  a_readdata_holds: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
endmodule : asc_audio_link_props
bind asc_audio_link asc_audio_link_props u_asc_audio_link_props (.ref_clk(ref_clk), .reset_n(reset_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq(irq), .sck_out(sck_out), .sck_oe(sck_oe), .ws_oe(ws_oe));

// ---- test/asc_link_partner.sv ----
`timescale 1ns/1ps
module asc_link_partner (
  input  wire logic        run,
  input  wire logic        sck_w,
  input  wire logic        ws_w,
  input  wire logic        sd_dev,
  input  wire logic [15:0] left_tx,
  input  wire logic [15:0] right_tx,
  output logic             sck,
  output logic             ws,
  output logic             sd,
  output logic [15:0]      left_rx,
  output logic [15:0]      right_rx
);
  logic [3:0]  cnt_ff;
  logic [15:0] sh_ff;
  logic        last_ws_ff;
  logic [3:0]  bit_idx;
  assign bit_idx = 4'h0 - cnt_ff;
  // link clock, parked low while run is low
  initial begin
    sck = 1'b0;
    ws = 1'b0;
    sd = 1'b0;
    cnt_ff = 4'h0;
    sh_ff = 16'h0;
    last_ws_ff = 1'b0;
    #3.3;
    forever begin
      #62.5;
      if (run || sck) sck = ~sck;
    end
  end
  // ws flips with the last bit, msb follows one bit later
  always @(negedge sck) begin
    sd <= ws ? right_tx[bit_idx] : left_tx[bit_idx];
    if (cnt_ff == 4'h0) ws <= ~ws;
    cnt_ff <= cnt_ff + 4'h1;
  end
  // released data line does not keep its last level
  always @(negedge run) sd <= ~sd;
  // capture device words on the wire clock
  always @(posedge sck_w) begin
    if (ws_w && !last_ws_ff) left_rx <= {sh_ff[14:0], sd_dev};
    if (!ws_w && last_ws_ff) right_rx <= {sh_ff[14:0], sd_dev};
    sh_ff <= {sh_ff[14:0], sd_dev};
    last_ws_ff <= ws_w;
  end
endmodule : asc_link_partner

// ---- test/tb_asc_audio_link.sv ----
`timescale 1ns/1ps
`include "asc_params.svh"
module tb_asc_audio_link;
  typedef struct packed {logic we; logic [15:0] a; logic [7:0] d;} asc_row_t;
  logic                   ref_clk;
  logic                   reset_n;
  logic [`ASC_ADDR_W-1:0] avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   irq, sck_out, sck_oe, ws_out, ws_oe, sd_out;
  logic                   p_sck, p_ws, p_sd, run;
  logic [15:0]            left_tx, right_tx, left_rx, right_rx;
  asc_pkg::asc_serial_t   lnk;
  int                     bad_count, compares, n, m;
  logic [7:0]             q, q2;
  asc_row_t rows [22] = '{'{0,`ASC_IDX_CFG0,8'h00}, '{0,`ASC_IDX_IRQ_MASK,8'h03}, '{0,`ASC_IDX_STAT,8'h00},
    '{1,`ASC_IDX_CFG0,8'h20}, '{1,`ASC_IDX_DATH,8'h80}, '{0,`ASC_IDX_DATH,8'h7d}, '{0,`ASC_IDX_DATL,8'h7c},
    '{1,`ASC_IDX_DATH,8'h00}, '{0,`ASC_IDX_DATH,8'h82}, '{0,`ASC_IDX_DATL,8'h84}, '{1,`ASC_IDX_DATH,8'hff},
    '{0,`ASC_IDX_DATH,8'h00}, '{1,`ASC_IDX_CFG0,8'h10}, '{1,`ASC_IDX_DATL,8'h7c}, '{1,`ASC_IDX_DATH,8'h7d},
    '{0,`ASC_IDX_DATH,8'h80}, '{1,`ASC_IDX_DATL,8'h00}, '{1,`ASC_IDX_DATH,8'h00}, '{0,`ASC_IDX_DATH,8'hff},
    '{1,16'hdf47,8'h55}, '{0,16'hdf47,8'h00}, '{0,`ASC_IDX_CFG0,8'h10}};
  // wire level from the device's output enables, the partner drives sck and ws otherwise
  assign lnk.sck = sck_oe ? sck_out : p_sck;
  assign lnk.ws  = ws_oe ? ws_out : p_ws;
  assign lnk.sd  = sd_out;
  asc_audio_link u_asc_audio_link (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .sck_in(lnk.sck),
    .ws_in(lnk.ws), .sd_in(p_sd), .sck_out(sck_out), .sck_oe(sck_oe), .ws_out(ws_out), .ws_oe(ws_oe),
    .sd_out(sd_out));
  asc_link_partner u_asc_link_partner (.run(run), .sck_w(lnk.sck), .ws_w(lnk.ws), .sd_dev(lnk.sd),
    .left_tx(left_tx), .right_tx(right_tx), .sck(p_sck), .ws(p_ws), .sd(p_sd), .left_rx(left_rx),
    .right_rx(right_rx));
  always #5 ref_clk = ~ref_clk;
  task automatic give_verdict();
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [15:0] a, input logic [7:0] d, output logic [7:0] r);
    int k;
    k = 0;
    @(posedge ref_clk);
    avs_address <= {a, 2'b00};
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    r = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 40) chk("waitrequest", 16'h1, 16'h0);
    if (k >= 40) give_verdict();
  endtask : bus
  task automatic poll(input logic [15:0] a, input logic [7:0] m);
    int k;
    logic [7:0] v;
    k = 0;
    do begin
      bus(1'b0, a, 8'h00, v);
      k++;
    end while ((v & m) == 8'h00 && k < 600);
    if (k >= 600) chk("poll", {8'h00, v}, {8'h00, m});
    if (k >= 600) give_verdict();
  endtask : poll
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 2000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 2000) chk("irq", 16'h0, 16'h1);
    if (k >= 2000) give_verdict();
  endtask : wait_irq
  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {bad_count, compares, run} = '0;
    left_tx = 16'h7d7c;
    right_tx = 16'h0000;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    // register table and standalone conversion
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].a, rows[i].d, q);
      if (!rows[i].we) chk("row read", {8'h00, q}, {8'h00, rows[i].d});
    end
    // slave receive, mono then stereo, compressed
    bus(1'b1, `ASC_IDX_CFG0, 8'h15, q);
    run = 1'b1;
    repeat (3) begin
      poll(`ASC_IDX_STAT, 8'h01);
      bus(1'b0, `ASC_IDX_DATH, 8'h00, q);
      chk("rx mono word", {8'h00, q}, 16'h0080);
      bus(1'b0, `ASC_IDX_STAT, 8'h00, q);
      chk("rx flag", 16'(q[0]), 16'h0);
    end
    chk("slave sck drive", 16'(sck_oe), 16'h0);
    bus(1'b1, `ASC_IDX_CFG0, 8'h11, q);
    poll(`ASC_IDX_STAT, 8'h01);
    bus(1'b0, `ASC_IDX_DATH, 8'h00, q);
    poll(`ASC_IDX_STAT, 8'h01);
    bus(1'b0, `ASC_IDX_DATH, 8'h00, q2);
    chk("rx stereo pair", {8'h00, q ^ q2}, 16'h007f);
    // slave transmit mono, expanded, with interrupt
    bus(1'b1, `ASC_IDX_CFG0, 8'ha9, q);
    repeat (6) begin
      wait_irq();
      bus(1'b1, `ASC_IDX_DATH, 8'h80, q);
      bus(1'b0, `ASC_IDX_STAT, 8'h00, q);
      chk("tx flag", 16'(q[1]), 16'h0);
    end
    chk("tx left", left_rx, 16'h7d7c);
    chk("tx right", right_rx, 16'h7d7c);
    bus(1'b1, `ASC_IDX_IRQ_MASK, 8'h01, q);
    poll(`ASC_IDX_STAT, 8'h02);
    chk("irq masked", 16'(irq), 16'h0);
    bus(1'b1, `ASC_IDX_STAT, 8'h02, q);
    bus(1'b0, `ASC_IDX_STAT, 8'h00, q);
    chk("tx flag cleared", 16'(q[1]), 16'h0);
    bus(1'b1, `ASC_IDX_IRQ_MASK, 8'h03, q);
    wait_irq();
    bus(1'b1, `ASC_IDX_CFG0, 8'h29, q);
    repeat (2) @(posedge ref_clk);
    chk("irq disabled", 16'(irq), 16'h0);
    run = 1'b0;
    // master clock generation, sck and ws change counts over 2048 cycles
    bus(1'b1, `ASC_IDX_CFG0, 8'h03, q);
    repeat (100) @(negedge ref_clk);
    chk("master drive", {14'h0, sck_oe, ws_oe}, 16'h0003);
    n = 0;
    m = 0;
    q = {6'h0, ws_out, sck_out};
    repeat (2048) begin
      @(negedge ref_clk);
      if (sck_out !== q[0]) n++;
      if (ws_out !== q[1]) m++;
      q = {6'h0, ws_out, sck_out};
    end
    chk("sck changes", 16'(n), 16'h0040);
    chk("ws changes", 16'(m), 16'h0002);
    bus(1'b1, `ASC_IDX_CFG0, 8'h02, q);
    repeat (4) @(negedge ref_clk);
    chk("disabled drive", 16'(sck_oe), 16'h0);
    // reset in mid-run
    bus(1'b1, `ASC_IDX_CFG0, 8'h03, q);
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    bus(1'b0, `ASC_IDX_CFG0, 8'h00, q);
    chk("cfg after reset", {8'h00, q}, 16'h0000);
    give_verdict();
  end
endmodule : tb_asc_audio_link
